// *** common/tcpcmd_pkg.sv ***
// Purpose: Constants for the port command interpreter and safe-zero status
// Assumes: Byte-wide register port, one access per cycle
// Notes  : Functional notes below
//
// Functional notes
// - Safe-zero flag follows comparator below 0.8V while detection is enabled
// - Alert-extension writes change nothing
// - Timer and fast-swap bits always read zero
// - Command register cleared after acting
// - 0x22 disables detection unless sourcing, 0x33 enables it
// - 0x66 stops sourcing, detection unchanged
// - 0x77 sources default, enables detection
// - 0x77 returns non-default output to default
// - 0x88 drives non-default target when sourcing
// - 0x99 restarts connection unless roles differ
// - 0xaa arms receive-detect clear after GoodCRC
// - 0xdd resets transmit pointer, invalidates buffer
// - 0xee resets receive read pointer to one
// - 0xee leaves receive contents untouched
// - 0x11, 0x44, 0x45 accepted without action
// - Disable-detect while sourcing flags interface error
// - Command register reads zero, no error
package tcpcmd_pkg;
  localparam logic [7:0] TCPCMD_ADDR_STATUS_EXT = 8'h20;
  localparam logic [7:0] TCPCMD_ADDR_ALERT_EXT  = 8'h21;
  localparam logic [7:0] TCPCMD_ADDR_COMMAND    = 8'h23;
  localparam logic [7:0] TCPCMD_RESET_VALUE     = 8'h00;
  localparam logic [7:0] TCPCMD_BUF_START       = 8'h01;

  localparam logic [7:0] TCPCMD_DIS_DETECT  = 8'h22;
  localparam logic [7:0] TCPCMD_EN_DETECT   = 8'h33;
  localparam logic [7:0] TCPCMD_DIS_SOURCE  = 8'h66;
  localparam logic [7:0] TCPCMD_SRC_DEFAULT = 8'h77;
  localparam logic [7:0] TCPCMD_SRC_NONDEF  = 8'h88;
  localparam logic [7:0] TCPCMD_RESTART_CON = 8'h99;
  localparam logic [7:0] TCPCMD_RX_ONE_MORE = 8'haa;
  localparam logic [7:0] TCPCMD_RESET_TX    = 8'hdd;
  localparam logic [7:0] TCPCMD_RESET_RX    = 8'hee;
  localparam logic [7:0] TCPCMD_WAKE        = 8'h11;
  localparam logic [7:0] TCPCMD_DIS_SINK    = 8'h44;
  localparam logic [7:0] TCPCMD_SINK        = 8'h45;

  typedef enum logic [2:0] {
    TCPCMD_OUT_OFF     = 3'h1,
    TCPCMD_OUT_DEFAULT = 3'h2,
    TCPCMD_OUT_NONDEF  = 3'h4
  } tcpcmd_out_t;
endpackage : tcpcmd_pkg

// *** logic/tcpcmd_decode.sv ***
// Purpose: Classify a command byte into action strobes
// Assumes: Combinational, used inside the interpreter
// Notes  : Unlisted codes raise no strobe
`timescale 1ns/10ps
module tcpcmd_decode (
  input  wire logic [7:0] code,
  output logic            dis_det,
  output logic            en_det,
  output logic            dis_src,
  output logic            src_def,
  output logic            src_nd,
  output logic            restart,
  output logic            rx_one,
  output logic            rst_tx,
  output logic            rst_rx
);
  import tcpcmd_pkg::*;

  always_comb
  begin
    dis_det = (code == TCPCMD_DIS_DETECT);
    en_det  = (code == TCPCMD_EN_DETECT);
    dis_src = (code == TCPCMD_DIS_SOURCE);
    src_def = (code == TCPCMD_SRC_DEFAULT);
    src_nd  = (code == TCPCMD_SRC_NONDEF);
    restart = (code == TCPCMD_RESTART_CON);
    rx_one  = (code == TCPCMD_RX_ONE_MORE);
    rst_tx  = (code == TCPCMD_RESET_TX);
    rst_rx  = (code == TCPCMD_RESET_RX);
  end
endmodule : tcpcmd_decode

// *** logic/tcpcmd_top.sv ***
// Purpose: Port command interpreter with safe-zero status
// Assumes: Register writes/reads are single-cycle strobes with address
// Notes  : Command acted on the cycle after the write
`timescale 1ns/10ps
module tcpcmd_top (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       below_safe_zero,
  input  wire logic       cc_line_one_role,
  input  wire logic       cc_line_two_role,
  input  wire logic       goodcrc_sent,
  output logic [7:0]      reg_rdata,
  output logic            vbus_safe_zero_flag,
  output logic            vbus_detection_enable,
  output logic            source_enable,
  output logic            source_nondefault,
  output logic            restart_connection,
  output logic            rx_one_more_armed,
  output logic            receive_detect_clear,
  output logic            tx_pointer_reset,
  output logic            tx_buffer_invalidate,
  output logic            rx_pointer_reset,
  output logic            interface_error
);
  import tcpcmd_pkg::*;

  // ----------------------------------------------------------------
  // Command holding register
  // ----------------------------------------------------------------
  logic [7:0]  port_command;
  logic        cmd_pending;
  tcpcmd_out_t out_state;
  logic d_dis_det, d_en_det, d_dis_src, d_src_def, d_src_nd;
  logic d_restart, d_rx_one, d_rst_tx, d_rst_rx;
  logic wr_cmd;

  assign wr_cmd = reg_wr && (reg_addr == TCPCMD_ADDR_COMMAND);

  tcpcmd_decode u_decode (
    .code    (port_command),
    .dis_det (d_dis_det),
    .en_det  (d_en_det),
    .dis_src (d_dis_src),
    .src_def (d_src_def),
    .src_nd  (d_src_nd),
    .restart (d_restart),
    .rx_one  (d_rx_one),
    .rst_tx  (d_rst_tx),
    .rst_rx  (d_rst_rx)
  );

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      port_command <= TCPCMD_RESET_VALUE;
      cmd_pending  <= 1'b0;
    end
    else if (wr_cmd)
    begin
      port_command <= reg_wdata;
      cmd_pending  <= 1'b1;
    end
    else
    begin
      port_command <= TCPCMD_RESET_VALUE;
      cmd_pending  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Detection enable
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      vbus_detection_enable <= 1'b0;
    else if (cmd_pending && (d_en_det || d_src_def))
      vbus_detection_enable <= 1'b1;
    else if (cmd_pending && d_dis_det && out_state == TCPCMD_OUT_OFF)
      vbus_detection_enable <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Output path state
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      out_state <= TCPCMD_OUT_OFF;
    else if (cmd_pending)
    begin
      unique case (out_state)
        TCPCMD_OUT_OFF:
          if (d_src_def)
            out_state <= TCPCMD_OUT_DEFAULT;
        TCPCMD_OUT_DEFAULT:
          if (d_dis_src)
            out_state <= TCPCMD_OUT_OFF;
          else if (d_src_nd)
            out_state <= TCPCMD_OUT_NONDEF;
        TCPCMD_OUT_NONDEF:
          if (d_dis_src)
            out_state <= TCPCMD_OUT_OFF;
          else if (d_src_def)
            out_state <= TCPCMD_OUT_DEFAULT;
        default:
          out_state <= TCPCMD_OUT_OFF;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      source_enable     <= 1'b0;
      source_nondefault <= 1'b0;
    end
    else
    begin
      source_enable     <= (out_state != TCPCMD_OUT_OFF);
      source_nondefault <= (out_state == TCPCMD_OUT_NONDEF);
    end
  end

  // ----------------------------------------------------------------
  // Safe-zero status
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      vbus_safe_zero_flag <= 1'b0;
    else
      vbus_safe_zero_flag <= vbus_detection_enable && below_safe_zero;
  end

  // ----------------------------------------------------------------
  // Connection and buffer strobes
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      restart_connection   <= 1'b0;
      tx_pointer_reset     <= 1'b0;
      tx_buffer_invalidate <= 1'b0;
      rx_pointer_reset     <= 1'b0;
    end
    else
    begin
      restart_connection   <= cmd_pending && d_restart && (cc_line_one_role == cc_line_two_role);
      tx_pointer_reset     <= cmd_pending && d_rst_tx;
      tx_buffer_invalidate <= cmd_pending && d_rst_tx;
      rx_pointer_reset     <= cmd_pending && d_rst_rx;
    end
  end

  // Armed until the next GoodCRC goes out; a new arm wins over the clear
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rx_one_more_armed    <= 1'b0;
      receive_detect_clear <= 1'b0;
    end
    else
    begin
      receive_detect_clear <= rx_one_more_armed && goodcrc_sent;
      if (cmd_pending && d_rx_one)
        rx_one_more_armed <= 1'b1;
      else if (goodcrc_sent)
        rx_one_more_armed <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Interface error
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      interface_error <= 1'b0;
    else
      interface_error <= cmd_pending && d_dis_det && (out_state != TCPCMD_OUT_OFF);
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      reg_rdata <= TCPCMD_RESET_VALUE;
    else if (reg_rd && reg_addr == TCPCMD_ADDR_STATUS_EXT)
      reg_rdata <= {7'h00, vbus_safe_zero_flag};
    else
      reg_rdata <= TCPCMD_RESET_VALUE;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_cmd(logic [7:0] c);
    reg_wr && reg_addr == TCPCMD_ADDR_COMMAND && reg_wdata == c;
  endsequence

  property p_clear;
    @(posedge clk) disable iff (reset) wr_cmd ##1 !wr_cmd |=> port_command == TCPCMD_RESET_VALUE;
  endproperty
  a_clear: assert property (p_clear) else $error("command not cleared");

  property p_en;
    @(posedge clk) disable iff (reset) s_cmd(TCPCMD_EN_DETECT) |=> ##1 vbus_detection_enable;
  endproperty
  a_en: assert property (p_en) else $error("detect not enabled");

  property p_def;
    @(posedge clk) disable iff (reset) s_cmd(TCPCMD_SRC_DEFAULT) |=> ##2 source_enable && !source_nondefault;
  endproperty
  a_def: assert property (p_def) else $error("default not sourced");

  property p_stop;
    @(posedge clk) disable iff (reset)
      s_cmd(TCPCMD_DIS_SOURCE) |=> ##1 $stable(vbus_detection_enable) ##1 !source_enable;
  endproperty
  a_stop: assert property (p_stop) else $error("sourcing not stopped");

  property p_err;
    @(posedge clk) disable iff (reset)
      s_cmd(TCPCMD_DIS_DETECT) ##0 (source_enable && out_state != TCPCMD_OUT_OFF)
        |=> ##1 interface_error;
  endproperty
  a_err: assert property (p_err) else $error("missing interface error");

  property p_rd_zero;
    @(posedge clk) disable iff (reset) reg_rd && reg_addr == TCPCMD_ADDR_COMMAND |=> reg_rdata == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("command read not zero");

  property p_alert_zero;
    @(posedge clk) disable iff (reset) reg_rd && reg_addr == TCPCMD_ADDR_ALERT_EXT |=> reg_rdata == 8'h00;
  endproperty
  a_alert_zero: assert property (p_alert_zero) else $error("alert read not zero");

  property p_safe;
    @(posedge clk) disable iff (reset) vbus_detection_enable && below_safe_zero |=> vbus_safe_zero_flag;
  endproperty
  a_safe: assert property (p_safe) else $error("safe-zero flag wrong");

  property p_restart;
    @(posedge clk) disable iff (reset) restart_connection |-> $past(cc_line_one_role) == $past(cc_line_two_role);
  endproperty
  a_restart: assert property (p_restart) else $error("restart with differing roles");

  property p_rxptr;
    @(posedge clk) disable iff (reset) s_cmd(TCPCMD_RESET_RX) |=> ##1 rx_pointer_reset;
  endproperty
  a_rxptr: assert property (p_rxptr) else $error("rx pointer not reset");

  // ----------------------------------------------------------------
  // Command outcome checks, judged on the state seen when acted on
  // ----------------------------------------------------------------
  sequence s_act(logic [7:0] c);
    s_cmd(c) ##1 cmd_pending;
  endsequence

  sequence s_unsup;
    reg_wr && reg_addr == TCPCMD_ADDR_COMMAND &&
      (reg_wdata == TCPCMD_WAKE || reg_wdata == TCPCMD_DIS_SINK || reg_wdata == TCPCMD_SINK) ##1 cmd_pending;
  endsequence

  property p_nondef;
    @(posedge clk) disable iff (reset)
      s_act(TCPCMD_SRC_NONDEF) ##0 (out_state == TCPCMD_OUT_DEFAULT)
        |=> (out_state == TCPCMD_OUT_NONDEF) ##1 source_nondefault;
  endproperty
  a_nondef: assert property (p_nondef) else $error("non-default level not reached");

  property p_back_def;
    @(posedge clk) disable iff (reset)
      s_act(TCPCMD_SRC_DEFAULT) ##0 (out_state == TCPCMD_OUT_NONDEF)
        |=> (out_state == TCPCMD_OUT_DEFAULT) ##1 (source_enable && !source_nondefault);
  endproperty
  a_back_def: assert property (p_back_def) else $error("default level not restored");

  property p_det_src;
    @(posedge clk) disable iff (reset)
      s_act(TCPCMD_SRC_DEFAULT) |=> vbus_detection_enable;
  endproperty
  a_det_src: assert property (p_det_src) else $error("detect not enabled by source");

  property p_keep_det;
    @(posedge clk) disable iff (reset)
      s_act(TCPCMD_DIS_DETECT) ##0 (out_state != TCPCMD_OUT_OFF)
        |=> $stable(vbus_detection_enable) && interface_error;
  endproperty
  a_keep_det: assert property (p_keep_det) else $error("detect dropped while sourcing");

  property p_dis_det;
    @(posedge clk) disable iff (reset)
      s_act(TCPCMD_DIS_DETECT) ##0 (out_state == TCPCMD_OUT_OFF)
        |=> !vbus_detection_enable && !interface_error;
  endproperty
  a_dis_det: assert property (p_dis_det) else $error("detect not disabled");

  property p_arm;
    @(posedge clk) disable iff (reset)
      s_cmd(TCPCMD_RX_ONE_MORE) |=> ##1 rx_one_more_armed;
  endproperty
  a_arm: assert property (p_arm) else $error("receive clear not armed");

  property p_rdc;
    @(posedge clk) disable iff (reset)
      receive_detect_clear |-> $past(rx_one_more_armed) && $past(goodcrc_sent);
  endproperty
  a_rdc: assert property (p_rdc) else $error("receive clear without arm");

  property p_txrst;
    @(posedge clk) disable iff (reset)
      s_cmd(TCPCMD_RESET_TX) |=> ##1 (tx_pointer_reset && tx_buffer_invalidate);
  endproperty
  a_txrst: assert property (p_txrst) else $error("tx buffer not reset");

  property p_restart_on;
    @(posedge clk) disable iff (reset)
      s_act(TCPCMD_RESTART_CON) ##0 (cc_line_one_role == cc_line_two_role) |=> restart_connection;
  endproperty
  a_restart_on: assert property (p_restart_on) else $error("restart missing");

  property p_restart_off;
    @(posedge clk) disable iff (reset)
      s_act(TCPCMD_RESTART_CON) ##0 (cc_line_one_role != cc_line_two_role) |=> !restart_connection;
  endproperty
  a_restart_off: assert property (p_restart_off) else $error("restart not ignored");

  property p_unsup;
    @(posedge clk) disable iff (reset)
      s_unsup |=> !(restart_connection || tx_pointer_reset || tx_buffer_invalidate || rx_pointer_reset ||
        interface_error) && $stable(vbus_detection_enable) && $stable(out_state);
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported command acted");

  property p_safe_clr;
    @(posedge clk) disable iff (reset)
      vbus_detection_enable && !below_safe_zero |=> !vbus_safe_zero_flag;
  endproperty
  a_safe_clr: assert property (p_safe_clr) else $error("safe-zero flag not cleared");

  property p_alert_wr;
    @(posedge clk) disable iff (reset)
      reg_wr && reg_addr == TCPCMD_ADDR_ALERT_EXT |=> !cmd_pending;
  endproperty
  a_alert_wr: assert property (p_alert_wr) else $error("alert write took effect");
endmodule : tcpcmd_top

// *** dv/tcpcmd_power_model.sv ***
// Purpose: Power path seen by the interpreter, feeding the safe-zero comparator
// Assumes: Output leaves safe zero one cycle after sourcing starts
// Notes  : Bleeds below the threshold four cycles after sourcing stops
`timescale 1ns/10ps
module tcpcmd_power_model (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic source_enable,
  output logic      below_safe_zero
);
  logic [1:0] bleed_count;

  always_ff @(posedge clk)
  begin
    if (reset || source_enable)
      bleed_count <= 2'h0;
    else if (bleed_count != 2'h3)
      bleed_count <= bleed_count + 2'h1;
  end

  always_ff @(posedge clk)
    below_safe_zero <= !reset && !source_enable && (bleed_count == 2'h3);
endmodule : tcpcmd_power_model

// *** dv/testbench.sv ***
// Purpose: Command sequences through the register port with expected results
// Assumes: Inputs change on the falling edge
// Notes  : Strobe pulses are counted and checked after selected commands
`timescale 1ns/10ps
module testbench;
  import tcpcmd_pkg::*;
  logic       clk, reset, reg_wr, reg_rd, below_safe_zero, cc_line_one_role, cc_line_two_role, goodcrc_sent;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
  logic       vbus_safe_zero_flag, vbus_detection_enable, source_enable, source_nondefault;
  logic       restart_connection, rx_one_more_armed, receive_detect_clear, tx_pointer_reset;
  logic       tx_buffer_invalidate, rx_pointer_reset, interface_error;
  logic [5:0] pulses;
  logic [7:0] cnt [6];
  int         num_errors, checks;
  logic [7:0] odd_codes [5] = '{8'h11, 8'h44, 8'h45, 8'h5a, 8'h00};

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  tcpcmd_top dut (.clk(clk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .below_safe_zero(below_safe_zero), .cc_line_one_role(cc_line_one_role),
    .cc_line_two_role(cc_line_two_role), .goodcrc_sent(goodcrc_sent), .reg_rdata(reg_rdata),
    .vbus_safe_zero_flag(vbus_safe_zero_flag), .vbus_detection_enable(vbus_detection_enable),
    .source_enable(source_enable), .source_nondefault(source_nondefault),
    .restart_connection(restart_connection), .rx_one_more_armed(rx_one_more_armed),
    .receive_detect_clear(receive_detect_clear), .tx_pointer_reset(tx_pointer_reset),
    .tx_buffer_invalidate(tx_buffer_invalidate), .rx_pointer_reset(rx_pointer_reset),
    .interface_error(interface_error));

  tcpcmd_power_model power (.clk(clk), .reset(reset), .source_enable(source_enable),
    .below_safe_zero(below_safe_zero));

  // ----------------------------------------
  // Pulse counters and tasks
  // ----------------------------------------
  assign pulses = {restart_connection, receive_detect_clear, tx_pointer_reset, tx_buffer_invalidate,
                   rx_pointer_reset, interface_error};

  always @(posedge clk)
    for (int i = 0; i < 6; i++)
      if (pulses[i] === 1'b1)
        cnt[i] <= cnt[i] + 8'h01;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = addr;
    reg_wdata = data;
    @(negedge clk);
    reg_wr = 1'b0;
    repeat (10) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = addr;
    @(negedge clk);
    reg_rd = 1'b0;
    data = reg_rdata;
  endtask : rd

  // Order: restart, rx-detect clear, tx reset, tx invalidate, rx reset, error
  task automatic pulses_are(input logic [5:0] exp);
    for (int i = 0; i < 6; i++)
    begin
      chk(cnt[i], {7'h0, exp[i]});
      cnt[i] = 8'h00;
    end
  endtask : pulses_are

  // Order: detect enable, source, non-default, armed, safe-zero flag
  task automatic lv(input logic [4:0] exp);
    chk({3'h0, vbus_detection_enable, source_enable, source_nondefault, rx_one_more_armed,
         vbus_safe_zero_flag}, {3'h0, exp});
  endtask : lv

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    {reset, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 1'b0, 1'b0, 8'h00, 8'h00};
    {cc_line_one_role, cc_line_two_role, goodcrc_sent} = 3'b000;
    num_errors = 0;
    checks = 0;
    for (int i = 0; i < 6; i++)
      cnt[i] = 8'h00;
    repeat (10) @(negedge clk);
    reset = 1'b0;
    lv(5'b00000);
    rd(TCPCMD_ADDR_COMMAND, rd_val); chk(rd_val, 8'h00);
    wr(TCPCMD_ADDR_ALERT_EXT, 8'hff);
    rd(TCPCMD_ADDR_ALERT_EXT, rd_val); chk(rd_val, 8'h00);
    lv(5'b00000);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_EN_DETECT); lv(5'b10001);
    rd(TCPCMD_ADDR_STATUS_EXT, rd_val); chk(rd_val, 8'h01);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_SRC_DEFAULT); lv(5'b11000);
    rd(TCPCMD_ADDR_COMMAND, rd_val); chk(rd_val, 8'h00);
    pulses_are(6'b000000);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_SRC_NONDEF); lv(5'b11100);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_SRC_DEFAULT); lv(5'b11000);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_DIS_DETECT); pulses_are(6'b000001);
    lv(5'b11000);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_DIS_SOURCE); lv(5'b10001);
    // A second stop while already off changes nothing
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_DIS_SOURCE); lv(5'b10001);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_DIS_DETECT); lv(5'b00000);
    pulses_are(6'b000000);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_RESTART_CON); pulses_are(6'b100000);
    cc_line_one_role = 1'b1;
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_RESTART_CON); pulses_are(6'b000000);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_RX_ONE_MORE); lv(5'b00010);
    @(negedge clk);
    goodcrc_sent = 1'b1;
    @(negedge clk);
    goodcrc_sent = 1'b0;
    repeat (5) @(negedge clk);
    pulses_are(6'b010000);
    lv(5'b00000);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_RESET_TX); pulses_are(6'b001100);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_RESET_RX); pulses_are(6'b000010);
    wr(TCPCMD_ADDR_COMMAND, TCPCMD_EN_DETECT);
    foreach (odd_codes[i])
      wr(TCPCMD_ADDR_COMMAND, odd_codes[i]);
    pulses_are(6'b000000);
    lv(5'b10001);
    print_verdict();
  end

  initial
  begin
    repeat (3000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule : testbench
